// file: barrel_shifter_operand_unit.sv
// Operand unit of the core: forms the second ALU operand or a transfer index
// through a 32-bit barrel shifter, with carry in and carry out.
// Assumes the decoder presents one request per cycle on the same clock and
// that the core loads its carry flag from flag_write/flag_value one edge later.
`timescale 1ns/1ps

module barrel_shifter_operand_unit
    import shifter_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          req_valid,
    input  operand_req_t       req,
    input  wire logic          carry_flag,
    output logic               out_valid,
    output logic [DATA_W-1:0]  out_result,
    output logic               out_carry,
    output logic               flag_write,
    output logic               flag_value,
    output logic               form_refused
);

    // Forms that carry no shift through an index register
    function automatic logic data_only_form(input operand_form_t form);
        data_only_form = (form == form_reg_amount) || (form == form_rotated_imm);
    endfunction

    // Whether the shifter carry may reach the status carry flag
    function automatic logic carry_updates(input operand_req_t r);
        carry_updates = r.set_flags && r.logical_op;
    endfunction

    // ------------------------------------------------------------------
    // Stage 1: capture the request and resolve its effective operation
    // ------------------------------------------------------------------
    operand_req_t req_q;
    logic         stage_valid;
    logic         stage_refused;
    logic         next_refused;
    shift_dec_t   dec;

    assign next_refused = req.index_path && data_only_form(req.form);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage_valid <= 1'b0;
        end else begin
            stage_valid <= req_valid && !next_refused;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage_refused <= 1'b0;
        end else begin
            stage_refused <= req_valid && next_refused;
        end
    end

    // Request words need no reset; stage_valid qualifies them
    always_ff @(posedge clk) begin
        if (req_valid) begin
            req_q <= req;
        end
    end

    shift_amount_decode u_decode (
        .req (req_q),
        .dec (dec)
    );

    // ------------------------------------------------------------------
    // Carry input selection
    // ------------------------------------------------------------------
    // The core loads its flag one edge after flag_write shows, so an op
    // right behind a flag-setting op would see a stale flag. Forward it.
    logic       carry_in;
    shift_res_t res;

    always_comb begin
        carry_in = carry_flag;
        if (flag_write) begin
            carry_in = flag_value;
        end
    end

    shift_engine u_engine (
        .dec      (dec),
        .carry_in (carry_in),
        .res      (res)
    );

    // ------------------------------------------------------------------
    // Stage 2: registered results
    // ------------------------------------------------------------------
    logic next_flag_write;

    assign next_flag_write = stage_valid && carry_updates(req_q);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= stage_valid;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_result <= DATA_ZERO;
            out_carry  <= 1'b0;
        end else if (stage_valid) begin
            out_result <= res.value;
            out_carry  <= res.carry;
        end
    end

    // flag_value holds its value when not writing and flag_write drops low, so the flag stays unchanged
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_write <= 1'b0;
        end else begin
            flag_write <= next_flag_write;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_value <= 1'b0;
        end else if (next_flag_write) begin
            flag_value <= res.carry;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            form_refused <= 1'b0;
        end else begin
            form_refused <= stage_refused;
        end
    end

endmodule // barrel_shifter_operand_unit

// file: shifter_pkg.sv
// Shared types and constants for the barrel shifter operand unit.
// Assumes the instruction decoder fills in an operand request per cycle.
package shifter_pkg;

    localparam int unsigned DATA_W     = 32;
    localparam int unsigned IMM_AMT_W  = 5;
    localparam int unsigned COUNT_W    = 8;
    localparam int unsigned IMM8_W     = 8;
    localparam int unsigned ROT_W      = 4;
    localparam int unsigned AMT_W      = 6;

    localparam logic [AMT_W-1:0]      AMT_ZERO   = 6'h00;
    localparam logic [AMT_W-1:0]      AMT_FULL   = 6'h20;
    localparam logic [COUNT_W-1:0]    COUNT_FULL = 8'h20;
    localparam logic [COUNT_W-1:0]    COUNT_ZERO = 8'h00;
    localparam logic [IMM_AMT_W-1:0]  IMM_ZERO   = 5'h00;
    localparam logic [ROT_W-1:0]      ROT_ZERO   = 4'h0;
    localparam logic [DATA_W-1:0]     DATA_ZERO  = 32'h0000_0000;
    localparam logic [DATA_W-IMM8_W-1:0] IMM_PAD = 24'h00_0000;
    localparam int unsigned           SIGN_BIT   = 31;

    // Instruction encoding of the shift kind
    typedef enum logic [1:0] {
        logical_left_shift    = 2'h0,
        logical_right_shift   = 2'h1,
        sign_fill_right_shift = 2'h2,
        rotate_right          = 2'h3
    } shift_kind_t;

    // Left arithmetic shift is the same operation as the logical one
    localparam shift_kind_t arith_left_shift_alias = logical_left_shift;

    typedef enum logic [1:0] {
        form_imm_amount  = 2'h0,
        form_reg_amount  = 2'h1,
        form_rotated_imm = 2'h2,
        form_unshifted   = 2'h3
    } operand_form_t;

    // Operation actually carried out after special amounts are resolved
    typedef enum logic [2:0] {
        eff_pass             = 3'h0,
        eff_lsl              = 3'h1,
        eff_lsr              = 3'h2,
        eff_asr              = 3'h3,
        eff_ror              = 3'h4,
        rotate_through_carry = 3'h5
    } eff_kind_t;

    typedef struct packed {
        logic [DATA_W-1:0]    shift_source_operand;
        logic [DATA_W-1:0]    shift_count_reg;
        logic [IMM_AMT_W-1:0] imm_amount;
        shift_kind_t          kind;
        operand_form_t        form;
        logic [IMM8_W-1:0]    imm_value;
        logic [ROT_W-1:0]     imm_rot;
        logic                 index_path;
        logic                 set_flags;
        logic                 logical_op;
    } operand_req_t;

    typedef struct packed {
        eff_kind_t         eff;
        logic [AMT_W-1:0]  amount;
        logic              beyond;
        logic [DATA_W-1:0] value;
    } shift_dec_t;

    typedef struct packed {
        logic [DATA_W-1:0] value;
        logic              carry;
    } shift_res_t;

endpackage

// file: shift_amount_decode.sv
// Resolves shift form, kind and amount into one effective operation.
// Purely combinational; fed from a registered request.
`timescale 1ns/1ps
module shift_amount_decode
    import shifter_pkg::*;
(
    input  operand_req_t req,
    output shift_dec_t   dec
);

    function automatic eff_kind_t map_kind(input shift_kind_t kind);
        case (kind)
            logical_left_shift:    map_kind = eff_lsl;
            logical_right_shift:   map_kind = eff_lsr;
            sign_fill_right_shift: map_kind = eff_asr;
            rotate_right:          map_kind = eff_ror;
            default:               map_kind = eff_pass;
        endcase
    endfunction

    logic [COUNT_W-1:0] count_byte;

    assign count_byte = req.shift_count_reg[COUNT_W-1:0];

    always_comb begin
        dec.eff    = eff_pass;
        dec.amount = AMT_ZERO;
        dec.beyond = 1'b0;
        dec.value  = req.shift_source_operand;
        case (req.form)
            form_imm_amount: begin
                if (req.imm_amount == IMM_ZERO) begin
                    case (req.kind)
                        logical_right_shift: begin
                            dec.eff    = eff_lsr;
                            dec.amount = AMT_FULL;
                        end
                        sign_fill_right_shift: begin
                            dec.eff    = eff_asr;
                            dec.amount = AMT_FULL;
                        end
                        rotate_right: dec.eff = rotate_through_carry;
                        default:      dec.eff = eff_pass;
                    endcase
                end else begin
                    dec.eff    = map_kind(req.kind);
                    dec.amount = {1'b0, req.imm_amount};
                end
            end
            form_reg_amount: begin
                if (count_byte == COUNT_ZERO) begin
                    dec.eff = eff_pass;
                end else if (req.kind == rotate_right) begin
                    dec.eff    = eff_ror;
                    // Reduce into 1..32: a zero low field means 32
                    dec.amount = (count_byte[IMM_AMT_W-1:0] == IMM_ZERO) ? AMT_FULL
                                 : {1'b0, count_byte[IMM_AMT_W-1:0]};
                end else begin
                    dec.eff    = map_kind(req.kind);
                    dec.beyond = count_byte > COUNT_FULL;
                    dec.amount = (count_byte >= COUNT_FULL) ? AMT_FULL : count_byte[AMT_W-1:0];
                end
            end
            form_rotated_imm: begin
                dec.value = {IMM_PAD, req.imm_value};
                if (req.imm_rot != ROT_ZERO) begin
                    dec.eff    = eff_ror;
                    dec.amount = {1'b0, req.imm_rot, 1'b0};
                end
            end
            default: dec.eff = eff_pass;
        endcase
    end

endmodule // shift_amount_decode

// file: shift_engine.sv
// The shifting network itself: one effective operation, amount 0..32.
// Combinational; caller registers the result.
`timescale 1ns/1ps
module shift_engine
    import shifter_pkg::*;
(
    input  shift_dec_t dec,
    input  wire logic  carry_in,
    output shift_res_t res
);

    logic [DATA_W:0]     left_wide;
    logic [DATA_W:0]     right_wide;
    logic [DATA_W:0]     sign_wide;
    logic [2*DATA_W-1:0] rot_wide;

    // For the three shifts, an extra bit beside the word catches the last bit shifted out; the rotate takes it from bit 31
    assign left_wide  = {1'b0, dec.value} << dec.amount;
    assign right_wide = {dec.value, 1'b0} >> dec.amount;
    assign sign_wide  = 33'($signed({dec.value, 1'b0}) >>> dec.amount);
    assign rot_wide   = {dec.value, dec.value} >> dec.amount[IMM_AMT_W-1:0];

    always_comb begin
        res.value = dec.value;
        res.carry = carry_in;
        case (dec.eff)
            eff_lsl: begin
                res.value = dec.beyond ? DATA_ZERO : left_wide[DATA_W-1:0];
                res.carry = dec.beyond ? 1'b0 : left_wide[DATA_W];
            end
            eff_lsr: begin
                res.value = dec.beyond ? DATA_ZERO : right_wide[DATA_W:1];
                res.carry = dec.beyond ? 1'b0 : right_wide[0];
            end
            eff_asr: begin
                res.value = sign_wide[DATA_W:1];
                res.carry = dec.beyond ? dec.value[SIGN_BIT] : sign_wide[0];
            end
            eff_ror: begin
                res.value = rot_wide[DATA_W-1:0];
                res.carry = rot_wide[SIGN_BIT];
            end
            rotate_through_carry: begin
                res.value = {carry_in, dec.value[DATA_W-1:1]};
                res.carry = dec.value[0];
            end
            default: begin
                res.value = dec.value;
                res.carry = carry_in;
            end
        endcase
    end

endmodule // shift_engine

// file: status_carry_model.sv
// Status carry flag of the core, seen from the operand unit.
// Assumes the unit's clock; loads the shifter carry on flag_write.
`timescale 1ns/1ps
module status_carry_model (
    input  wire logic clk,
    input  wire logic preset,
    input  wire logic preset_value,
    input  wire logic flag_write,
    input  wire logic flag_value,
    output logic      carry
);
    // No reset of its own: the bench holds preset through reset so carry is never unknown
    always_ff @(posedge clk) begin
        if (preset) begin
            carry <= preset_value;
        end else if (flag_write) begin
            carry <= flag_value;
        end
    end
endmodule // status_carry_model

// file: barrel_shifter_operand_unit_sva.sv
// Port checker for the operand unit, bound to its top module.
// Assumes one clock and the asynchronous active-high reset.
`timescale 1ns/1ps
module shifter_sva
    import shifter_pkg::*;
(
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              req_valid,
    input operand_req_t           req,
    input wire logic              carry_flag,
    input wire logic              out_valid,
    input wire logic [DATA_W-1:0] out_result,
    input wire logic              out_carry,
    input wire logic              flag_write,
    input wire logic              flag_value,
    input wire logic              form_refused
);
    wire logic bad = req.index_path && req.form inside {form_reg_amount, form_rotated_imm};
    wire logic take = req_valid && !bad;
    wire logic fw = req.set_flags && req.logical_op;
    wire logic [DATA_W-1:0] src = req.shift_source_operand;
    wire logic imm0 = take && req.form == form_imm_amount && req.imm_amount == IMM_ZERO;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_answer_two_edges: assert property (take |-> ##2 (out_valid && !form_refused))
        else $error("accepted request gave no result");
    a_index_form_refused: assert property (req_valid && bad |-> ##2 (form_refused && !out_valid && !flag_write))
        else $error("index form not refused");
    a_flag_write_gate: assert property (take |-> ##2 (flag_write == $past(fw, 2)))
        else $error("flag write gating wrong");
    a_flag_carry_copy: assert property (flag_write |-> flag_value == out_carry)
        else $error("flag value differs from carry");
    a_result_holds: assert property (!out_valid |-> $stable(out_result) && $stable(out_carry))
        else $error("result moved without valid");
    a_left_zero_pass: assert property (imm0 && req.kind == logical_left_shift
        |-> ##2 out_result == $past(src, 2))
        else $error("left shift by zero altered operand");
    a_right_full_zero: assert property (imm0 && req.kind == logical_right_shift
        |-> ##2 (out_result == DATA_ZERO && out_carry == $past(src[SIGN_BIT], 2)))
        else $error("right shift by 32 wrong");
    a_sign_fill_full: assert property (imm0 && req.kind == sign_fill_right_shift
        |-> ##2 (out_result == {DATA_W{out_carry}} && out_carry == $past(src[SIGN_BIT], 2)))
        else $error("sign fill by 32 wrong");
    a_wide_shift_zero: assert property (take && req.form == form_reg_amount
        && req.shift_count_reg[7:0] > COUNT_FULL
        && req.kind inside {logical_left_shift, logical_right_shift}
        |-> ##2 (out_result == DATA_ZERO && !out_carry))
        else $error("wide shift not zero");
    c_refused: cover property (form_refused);
    c_flag_write: cover property (flag_write);
    c_back_to_back: cover property (take ##1 take);
endmodule // shifter_sva

bind barrel_shifter_operand_unit shifter_sva u_sva (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req(req), .carry_flag(carry_flag), .out_valid(out_valid), .out_result(out_result), .out_carry(out_carry),
    .flag_write(flag_write), .flag_value(flag_value), .form_refused(form_refused));

// file: test_barrel_shifter_operand_unit.sv
// Bench for the operand unit: shift kinds, wide counts, immediates, flags,
// refusals and carry forwarding. Assumes the status carry model as partner.
`timescale 1ns/1ps
module test_barrel_shifter_operand_unit;
    import shifter_pkg::*;
    logic              clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              req_valid = 1'b0;
    operand_req_t      req = '0;
    // Held through reset so the partner flag starts at a known value
    logic              preset = 1'b1;
    logic              preset_value = 1'b0;
    logic              carry_flag;
    logic              out_valid;
    logic [DATA_W-1:0] out_result;
    logic              out_carry;
    logic              flag_write;
    logic              flag_value;
    logic              form_refused;
    int                bad_count = 0;
    int                num_checks = 0;
    int                cycles = 0;

    barrel_shifter_operand_unit u_dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
        .carry_flag(carry_flag), .out_valid(out_valid), .out_result(out_result), .out_carry(out_carry),
        .flag_write(flag_write), .flag_value(flag_value), .form_refused(form_refused));
    status_carry_model u_carry (.clk(clk), .preset(preset), .preset_value(preset_value),
        .flag_write(flag_write), .flag_value(flag_value), .carry(carry_flag));

    initial forever #20 clk = ~clk;

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Carry in bit 32, result below
    function automatic logic [32:0] ref_shift(operand_req_t r, logic c);
        logic [31:0] a;
        logic [63:0] w;
        int          n;
        a = r.shift_source_operand;
        n = r.imm_amount;
        if (r.form == form_unshifted) return {c, a};
        if (r.form == form_rotated_imm) begin
            n = 2 * r.imm_rot;
            w = {2{24'h00_0000, r.imm_value}} >> n;
            return {n == 0 ? c : w[31], w[31:0]};
        end
        if (r.form == form_reg_amount) begin
            n = r.shift_count_reg[7:0];
            if (n == 0) return {c, a};
            if (r.kind == rotate_right) n = (n - 1) % 32 + 1;
        end else if (n == 0) begin
            if (r.kind == logical_left_shift) return {c, a};
            if (r.kind == rotate_right) return {a[0], c, a[31:1]};
            n = 32;
        end
        case (r.kind)
            logical_left_shift: begin
                w = {32'h0000_0000, a} << n;
                return w[32:0];
            end
            logical_right_shift: w = {a, 32'h0000_0000} >> n;
            sign_fill_right_shift: w = $signed({a, 32'h0000_0000}) >>> (n > 32 ? 32 : n);
            default: begin
                w = {a, a} >> n;
                return {w[31], w[31:0]};
            end
        endcase
        return {w[31], w[63:32]};
    endfunction

    function automatic operand_req_t mk(operand_form_t f, shift_kind_t k, logic [31:0] s, logic [31:0] n);
        mk = '0;
        mk.form = f;
        mk.kind = k;
        mk.shift_source_operand = s;
        mk.shift_count_reg = n;
        mk.imm_amount = n[4:0];
        mk.imm_value = n[7:0];
        mk.imm_rot = n[11:8];
        mk.set_flags = 1'b1;
        mk.logical_op = 1'b1;
    endfunction

    task automatic run(input operand_req_t r);
        logic        no;
        logic [32:0] e;
        no = r.index_path && r.form inside {form_reg_amount, form_rotated_imm};
        @(posedge clk);
        req <= r;
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        e = no ? {out_carry, out_result} : ref_shift(r, carry_flag);
        @(posedge clk);
        #1;
        check({out_valid, flag_write, form_refused}, {!no, !no && r.set_flags && r.logical_op, no});
        check({out_carry, out_result}, e);
    endtask

    task automatic set_carry(input logic v);
        @(posedge clk);
        preset <= 1'b1;
        preset_value <= v;
        @(posedge clk);
        preset <= 1'b0;
    endtask

    task automatic t_kinds();
        logic [7:0] amt [4] = '{8'h00, 8'h01, 8'h05, 8'h1F};
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 4; i++) begin
                run(mk(form_imm_amount, shift_kind_t'(k), 32'h8000_00F1, amt[i]));
                run(mk(form_reg_amount, shift_kind_t'(k), 32'h4C00_0003, {24'hA5_A5A5, amt[i]}));
            end
        end
    endtask

    task automatic t_wide();
        logic [7:0] amt [5] = '{8'h20, 8'h21, 8'h3F, 8'h40, 8'hFF};
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 5; i++) begin
                run(mk(form_reg_amount, shift_kind_t'(k), 32'h9000_0001, {24'hFF_FFFF, amt[i]}));
            end
        end
    endtask

    task automatic t_imm();
        set_carry(1'b1);
        for (int r = 0; r < 16; r++) begin
            run(mk(form_rotated_imm, logical_left_shift, 32'h0000_0000, {20'h0_0000, r[3:0], 8'h81}));
        end
    endtask

    task automatic t_flags();
        operand_req_t r;
        for (int f = 0; f < 4; f++) begin
            r = mk(form_imm_amount, logical_right_shift, 32'h0000_0001, 32'h0000_0001);
            r.set_flags = f[0];
            r.logical_op = f[1];
            set_carry(1'b0);
            run(r);
            @(posedge clk);
            #1;
            check({32'h0000_0000, carry_flag}, {32'h0000_0000, f == 3});
        end
    endtask

    task automatic t_refuse();
        operand_req_t r;
        for (int f = 0; f < 4; f++) begin
            r = mk(operand_form_t'(f), logical_left_shift, 32'h1234_5678, 32'h0000_0201);
            r.index_path = 1'b1;
            run(r);
        end
    endtask

    // Second request must see the first one's carry before the flag loads
    task automatic t_forward();
        operand_req_t r1;
        operand_req_t r2;
        logic [32:0]  e1;
        r1 = mk(form_imm_amount, logical_right_shift, 32'h0000_0003, 32'h0000_0001);
        r2 = mk(form_imm_amount, rotate_right, 32'h0000_0002, 32'h0000_0000);
        set_carry(1'b0);
        e1 = ref_shift(r1, 1'b0);
        @(posedge clk);
        req <= r1;
        req_valid <= 1'b1;
        @(posedge clk);
        req <= r2;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        check({out_carry, out_result}, e1);
        @(posedge clk);
        #1;
        check({out_carry, out_result}, ref_shift(r2, e1[32]));
    endtask

    initial begin
        repeat (5) @(posedge clk);
        #1;
        check({out_valid | out_carry | flag_write | flag_value | form_refused, out_result}, 33'h0_0000_0000);
        @(posedge clk);
        sys_rst <= 1'b0;
        preset <= 1'b0;
        t_kinds();
        t_wide();
        t_imm();
        t_flags();
        t_refuse();
        t_forward();
        complete_run();
    end
endmodule // test_barrel_shifter_operand_unit
